// ===== include/board_reset_pkg.sv
package board_reset_pkg;
	// clock rate
	localparam int unsigned CLK_HZ          = 200_000_000;
	// stretch and watchdog times, in milliseconds as printed
	localparam int unsigned STRETCH_MS      = 200;
	localparam int unsigned WDOG_NEW_MS     = 1000;
	localparam int unsigned WDOG_OLD_MS     = 70;
	// cycles per millisecond; derived counts use it
	localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
	localparam int unsigned STRETCH_CYC     = STRETCH_MS * CYC_PER_MS;
	localparam int unsigned WDOG_NEW_CYC    = WDOG_NEW_MS * CYC_PER_MS;
	localparam int unsigned WDOG_OLD_CYC    = WDOG_OLD_MS * CYC_PER_MS;
	// utility register
	localparam logic [9:0]  UTIL_ADDR       = 10'h37c;
	localparam logic [7:0]  UTIL_RESET      = 8'h00;
	localparam int unsigned UTIL_KICK_BIT   = 4;
	localparam int unsigned UTIL_ENABLE_BIT = 5;
	// watchdog states
	typedef enum logic [2:0] {
		WD_OFF   = 3'b001,
		WD_ARM   = 3'b010,
		WD_RUN   = 3'b100
	} wdog_state_t;
endpackage

// ===== include/reset_req_if.sv
`timescale 1ns/10ps
// reset request from watchdog into the stretcher
interface reset_req_if;
	logic board_reset;
	logic timeout;
	modport stretcher (output board_reset, input timeout);
	modport watchdog (input board_reset, output timeout);
endinterface : reset_req_if

// ===== hw/kick_watchdog.sv
`timescale 1ns/10ps
module kick_watchdog #(
	parameter int unsigned LIMIT_CYC = board_reset_pkg::WDOG_NEW_CYC
) (
	// clock and reset
	input  wire logic   clk_i,
	input  wire logic   reset_i,
	// kick and enable levels from the utility register
	input  wire logic   kick_i,
	input  wire logic   enable_i,
	// link to the stretcher
	reset_req_if.watchdog req
);
	localparam int unsigned W = $clog2(LIMIT_CYC + 1);

	// a limit below two leaves no room to count; refused at elaboration
	if (LIMIT_CYC < 2) begin : g_bad_limit
		$error("watchdog limit too small");
	end

	board_reset_pkg::wdog_state_t state_reg;
	logic [W-1:0]                 count_reg;
	logic                         kick_last_reg;
	logic                         kick_edge;
	logic                         at_limit;

	assign kick_edge = kick_i ^ kick_last_reg;
	assign at_limit  = (count_reg == W'(LIMIT_CYC - 1));

	// previous kick level for polarity detection
	always_ff @(posedge clk_i) begin
		if (reset_i || req.board_reset) begin
			kick_last_reg <= 1'b0;
		end else begin
			kick_last_reg <= kick_i;
		end
	end

	// off after any reset; steady level for the limit arms it
	// counter restarts on every kick polarity change
	always_ff @(posedge clk_i) begin
		if (reset_i || req.board_reset) begin
			state_reg <= board_reset_pkg::WD_OFF;
			count_reg <= '0;
			req.timeout <= 1'b0;
		end else begin
			req.timeout <= 1'b0;
			unique case (state_reg)
			board_reset_pkg::WD_OFF: begin
				count_reg <= '0;
				if (enable_i) begin
					state_reg <= board_reset_pkg::WD_ARM;
				end
			end
			board_reset_pkg::WD_ARM: begin
				if (!enable_i) begin
					state_reg <= board_reset_pkg::WD_OFF;
				end else if (kick_edge) begin
					count_reg <= '0;
				end else if (at_limit) begin
					count_reg <= '0;
					state_reg <= board_reset_pkg::WD_RUN;
				end else begin
					count_reg <= count_reg + W'(1);
				end
			end
			board_reset_pkg::WD_RUN: begin
				if (!enable_i) begin
					state_reg <= board_reset_pkg::WD_OFF;
				end else if (kick_edge) begin
					count_reg <= '0;
				end else if (at_limit) begin
					req.timeout <= 1'b1;
					count_reg   <= '0;
				end else begin
					count_reg <= count_reg + W'(1);
				end
			end
			default: begin
				state_reg <= board_reset_pkg::WD_OFF;
			end
			endcase
		end
	end
endmodule // kick_watchdog

// ===== hw/board_reset_watchdog.sv
`timescale 1ns/10ps
module board_reset_watchdog #(
	parameter int unsigned STRETCH_CYC = board_reset_pkg::STRETCH_CYC,
	parameter int unsigned WDOG_CYC    = board_reset_pkg::WDOG_NEW_CYC
) (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	// supply monitor: high while supply below threshold
	input  wire logic       supply_low_i,
	// external switch reset on the board_io_connector, active low
	input  wire logic       ext_reset_n_i,
	// i/o write port of the utility register
	input  wire logic [9:0] io_addr_i,
	input  wire logic [7:0] io_wdata_i,
	input  wire logic       io_write_i,
	// reset outputs and the utility register pins
	output logic            board_reset_o,
	output logic            bus_resetdrv_o,
	output logic [7:0]      utility_control_o
);
	// stretch counter width; it must hold STRETCH_CYC itself
	localparam int unsigned SW = $clog2(STRETCH_CYC + 1);

	// counts the logic cannot serve are refused at elaboration
	if (STRETCH_CYC < 1) begin : g_bad_stretch
		$error("stretch count must be positive");
	end
	if (WDOG_CYC < 2) begin : g_bad_wdog
		$error("watchdog limit must be two cycles or more");
	end

	// a write strobe aimed at the utility register
	function automatic logic util_write_hit(
		input logic [9:0] addr,
		input logic       write
	);
		return write && (addr == board_reset_pkg::UTIL_ADDR);
	endfunction

	// any reset cause present; the bus reset pin is not one
	function automatic logic any_source(
		input logic supply_low,
		input logic switch_n,
		input logic timeout
	);
		return supply_low || !switch_n || timeout;
	endfunction

	// switch synchroniser stages
	logic          ext_meta_reg;
	logic          ext_sync_reg;
	// stretcher
	logic          source;
	logic          stretch_busy;
	logic [SW-1:0] stretch_reg;
	logic [SW-1:0] stretch_next;
	logic          board_reset_reg;
	logic          board_reset_next;
	// utility register
	logic          write_hit;
	logic [7:0]    utility_reg;
	logic [7:0]    utility_next;
	// watchdog taps and link
	logic          kick_level;
	logic          wdog_enable;
	reset_req_if   req ();

	// two-flop synchroniser; a switch pulse has no timing relation to clk
	// reset to the released level so no false press follows reset
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ext_meta_reg <= 1'b1;
			ext_sync_reg <= 1'b1;
		end else begin
			ext_meta_reg <= ext_reset_n_i;
			ext_sync_reg <= ext_meta_reg;
		end
	end

	// reset causes; a one-cycle timeout is enough to start a stretch
	assign source = any_source(supply_low_i, ext_sync_reg,
		req.timeout);

	// counter still running after the last cause dropped
	assign stretch_busy = (stretch_reg != '0);

	// reload while a cause holds, so release counts from the last one;
	// a glitch still gets the full width, never a cut pulse
	always_comb begin
		stretch_next = stretch_reg;
		if (source) begin
			stretch_next = SW'(STRETCH_CYC);
		end else if (stretch_busy) begin
			stretch_next = stretch_reg - SW'(1);
		end
	end

	// stretch counter; reset loads it so power-up is stretched too
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			stretch_reg <= SW'(STRETCH_CYC);
		end else begin
			stretch_reg <= stretch_next;
		end
	end

	// internal reset level, one flop ahead of the pins
	assign board_reset_next = source || stretch_busy;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			board_reset_reg <= 1'b1;
		end else begin
			board_reset_reg <= board_reset_next;
		end
	end

	// the watchdog is held off while the board is in reset
	assign req.board_reset = board_reset_reg;

	// on-board reset pin straight from a flop
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			board_reset_o <= 1'b1;
		end else begin
			board_reset_o <= board_reset_reg;
		end
	end

	// bus reset follows on-board reset; output only, never sampled
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			bus_resetdrv_o <= 1'b1;
		end else begin
			bus_resetdrv_o <= board_reset_reg;
		end
	end

	assign write_hit = util_write_hit(io_addr_i, io_write_i);

	// writes that land during board reset are dropped, so software
	// cannot arm the watchdog before the stretch has ended
	always_comb begin
		utility_next = utility_reg;
		if (board_reset_reg) begin
			utility_next = board_reset_pkg::UTIL_RESET;
		end else if (write_hit) begin
			utility_next = io_wdata_i;
		end
	end

	// write-only utility register, cleared by any hardware reset
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			utility_reg <= board_reset_pkg::UTIL_RESET;
		end else begin
			utility_reg <= utility_next;
		end
	end

	// no read path exists; the pins show the flop for the board
	assign utility_control_o = utility_reg;

	// only bits 4 and 5 reach the watchdog
	assign kick_level  = utility_reg[board_reset_pkg::UTIL_KICK_BIT];
	assign wdog_enable = utility_reg[board_reset_pkg::UTIL_ENABLE_BIT];

	// steady kick arms the watchdog, then it times out
	kick_watchdog #(
		.LIMIT_CYC (WDOG_CYC)
	) u_watchdog (
		.clk_i    (clk_i),
		.reset_i  (reset_i),
		.kick_i   (kick_level),
		.enable_i (wdog_enable),
		.req      (req.watchdog)
	);
endmodule // board_reset_watchdog

// ===== sim/board_reset_watchdog_asserts.sv
`timescale 1ns/10ps
module board_reset_checker #(
	parameter int unsigned STRETCH_CYC = 50,
	parameter int unsigned WDOG_CYC    = 40
) (
	// watched ports
	input logic       clk_i,
	input logic       reset_i,
	input logic       supply_low_i,
	input logic       ext_reset_n_i,
	input logic [9:0] io_addr_i,
	input logic [7:0] io_wdata_i,
	input logic       io_write_i,
	input logic       board_reset_o,
	input logic       bus_resetdrv_o,
	input logic [7:0] utility_control_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	a_bus_copy: assert property (
		bus_resetdrv_o == board_reset_o) else $error("bus reset differs");
	a_supply_fires: assert property (
		supply_low_i |-> ##2 board_reset_o) else $error("supply reset late");
	a_switch_fires: assert property (
		!ext_reset_n_i |-> ##4 board_reset_o) else $error("switch reset late");
	a_stretch_min: assert property (
		$fell(board_reset_o) |-> !$past(supply_low_i, 40)
		&& $past(ext_reset_n_i, 40)) else $error("reset too short");
	a_pulse_hold: assert property (
		$rose(board_reset_o) |=> board_reset_o [*8]) else $error("glitch");
	// a reset needs a cause; an idle watchdog never fires
	a_reset_cause: assert property (
		$rose(board_reset_o) |-> $past(supply_low_i, 2)
		|| !$past(ext_reset_n_i, 4) || $past(utility_control_o[5]))
		else $error("reset without cause");
	a_util_write: assert property (
		io_write_i && io_addr_i == board_reset_pkg::UTIL_ADDR && !board_reset_o
		|=> utility_control_o == (board_reset_o ? board_reset_pkg::UTIL_RESET
		: $past(io_wdata_i))) else $error("write lost");
	a_util_clear: assert property (
		board_reset_o |-> utility_control_o == board_reset_pkg::UTIL_RESET)
		else $error("register not clear");
endmodule // board_reset_checker

bind board_reset_watchdog board_reset_checker #(
	.STRETCH_CYC(STRETCH_CYC),
	.WDOG_CYC(WDOG_CYC)
) chk (.*);

// ===== sim/io_host_model.sv
`timescale 1ns/10ps
module io_host_model (
	// clock
	input  logic       clk_i,
	// i/o write port
	output logic [9:0] io_addr_o,
	output logic [7:0] io_wdata_o,
	output logic       io_write_o
);
	// idle bus, strobe low
	initial begin
		io_addr_o = 10'h000;
		io_wdata_o = 8'h00;
		io_write_o = 1'b0;
	end
	// one byte write; only 37c reaches the watchdog
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk_i);
		io_addr_o <= a;
		io_wdata_o <= d;
		io_write_o <= 1'b1;
		@(posedge clk_i);
		io_write_o <= 1'b0;
	endtask
endmodule // io_host_model

// ===== sim/board_reset_watchdog_bench.sv
`timescale 1ns/10ps
module board_reset_watchdog_bench;
	localparam int unsigned S = 50;
	localparam int unsigned W = 40;
	logic       clk_i = 1'b0;
	logic       reset_i = 1'b1;
	logic       sup = 1'b0;
	logic       ext_n = 1'b1;
	logic [9:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       brst;
	logic       bdrv;
	logic [7:0] util;
	int         bad_count = 0;
	int         n_tests = 0;
	int         cyc = 0;
	int         n;
	always #2.5 clk_i = ~clk_i;
	io_host_model host (.clk_i(clk_i), .io_addr_o(addr), .io_wdata_o(wdata),
		.io_write_o(wr));
	board_reset_watchdog #(.STRETCH_CYC(S), .WDOG_CYC(W)) DUT (.clk_i(clk_i),
		.reset_i(reset_i), .supply_low_i(sup), .ext_reset_n_i(ext_n),
		.io_addr_i(addr), .io_wdata_i(wdata), .io_write_i(wr),
		.board_reset_o(brst), .bus_resetdrv_o(bdrv), .utility_control_o(util));
	task cmp(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	// cycles until reset reaches level v, bounded
	task wait_for(input logic v);
		n = 0;
		while (brst !== v && n < 1000) begin
			@(posedge clk_i);
			#1 n++;
		end
		cmp({7'h00, brst}, {7'h00, v});
	endtask
	task end_of_test();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// hang guard, far above the fewer than one thousand cycles needed
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			end_of_test();
		end
	end
	task t_reg();
		host.wr(10'h37c, 8'h5a);
		#1 cmp(util, 8'h5a);
		host.wr(10'h37d, 8'hff);
		#1 cmp(util, 8'h5a);
		repeat (4 * W) @(posedge clk_i);
		#1 cmp({7'h00, brst}, 8'h00);
	endtask
	// toggling kick faster than the limit holds off the timeout
	task t_wdog();
		for (int i = 0; i < 8; i++) begin
			host.wr(10'h37c, {3'b001, i[0], 4'h0});
			repeat (30) @(posedge clk_i);
		end
		#1 cmp({7'h00, brst}, 8'h00);
		wait_for(1'b1);
		cmp({6'h00, brst, bdrv}, 8'h03);
		cmp(8'(n + 30 >= 2 * W), 8'h01);
		cmp(util, 8'h00);
		wait_for(1'b0);
	endtask
	task t_src(input logic s);
		@(posedge clk_i);
		if (s)
			sup <= 1'b1;
		else
			ext_n <= 1'b0;
		@(posedge clk_i);
		ext_n <= 1'b1;
		repeat (s ? 1 : 3) @(posedge clk_i);
		#1 cmp({6'h00, brst, bdrv}, 8'h03);
		@(posedge clk_i);
		sup <= 1'b0;
		wait_for(1'b0);
		cmp(8'(n >= S), 8'h01);
	endtask
	// clearing the enable bit stops a running watchdog
	task t_off();
		host.wr(10'h37c, 8'h20);
		repeat (W + 10) @(posedge clk_i);
		host.wr(10'h37c, 8'h00);
		#1 cmp(util, 8'h00);
		repeat (3 * W) @(posedge clk_i);
		#1 cmp({7'h00, brst}, 8'h00);
	endtask
	initial begin
		repeat (12) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		#1 cmp(util, 8'h00);
		wait_for(1'b0);
		cmp(8'(n >= S), 8'h01);
		t_reg();
		t_wdog();
		t_src(1'b1);
		t_src(1'b0);
		t_off();
		end_of_test();
	end
endmodule // board_reset_watchdog_bench
